// ===== logic/sfir_pkg.sv
// Constants and types of the systolic FIR filter
`default_nettype none
package sfir_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_ROUND   = 8'h04;
  localparam logic [7:0]  OFF_STATUS  = 8'h08;
  localparam logic [7:0]  OFF_COEF    = 8'h40;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] ROUND_RST   = 32'h0000_0000;
  localparam logic [31:0] COEF_RST    = 32'h0000_0000;
  localparam int          CTRL_W      = 5;
  localparam int          ST_LAT_LSB  = 0;
  localparam int          ST_LAT_W    = 8;
  localparam int          ST_RDY_BIT  = 8;
  localparam int          ST_PEND_LSB = 9;
  localparam int          ST_SEL_LSB  = 16;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************
  // Datapath and timing
  // ****************************************
  localparam int          IP_RATIO      = 4;
  localparam int          IP_TAPS       = 12;
  localparam int          IP_PHASE_TAPS = 3;
  localparam int          IP_LAT        = 2;
  localparam int          SYS_LAT       = 4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_SYSTOLIC,
    MODE_SYMMETRIC,
    MODE_MULTICH,
    MODE_INTERP
  } sfir_mode_t;

  typedef enum logic [1:0] {
    XSEL_NONE,
    XSEL_DYNAMIC,
    XSEL_STATIC
  } sfir_xsel_t;

  typedef struct packed {
    sfir_xsel_t extra_adder_input_select;
    logic       swap;
    sfir_mode_t mode;
  } sfir_ctrl_t;

endpackage : sfir_pkg
`default_nettype wire

// ===== logic/sfir_top.sv
// Systolic FIR filter with symmetric, multichannel and interpolating forms
`timescale 1ns/1ps
`default_nettype none
module sfir_top #(
  parameter int            TAPS         = 12,
  parameter int            DW           = 16,
  parameter int            CW           = 16,
  parameter int            AW           = 48,
  parameter int            CH           = 4,
  parameter int            AXW          = 8,
  parameter logic [AW-1:0] STATIC_ROUND = '0
) (
  input  wire  logic                   aclk,
  input  wire  logic                   aresetn,
  input  wire  logic [DW-1:0]          in_data,
  input  wire  logic                   in_valid,
  output wire  logic                   in_ready,
  input  wire  logic [CH-1:0][DW-1:0]  ch_data,
  output wire  logic [AW-1:0]          result_data,
  output wire  logic                   result_valid,
  output wire  logic [((CH > 1) ? $clog2(CH) : 1)-1:0] result_chan,
  input  wire  logic [AXW-1:0]         awaddr,
  input  wire  logic [2:0]             awprot,
  input  wire  logic                   awvalid,
  output wire  logic                   awready,
  input  wire  logic [31:0]            wdata,
  input  wire  logic [3:0]             wstrb,
  input  wire  logic                   wvalid,
  output wire  logic                   wready,
  output wire  logic [1:0]             bresp,
  output wire  logic                   bvalid,
  input  wire  logic                   bready,
  input  wire  logic [AXW-1:0]         araddr,
  input  wire  logic [2:0]             arprot,
  input  wire  logic                   arvalid,
  output wire  logic                   arready,
  output wire  logic [31:0]            rdata,
  output wire  logic [1:0]             rresp,
  output wire  logic                   rvalid,
  input  wire  logic                   rready
);

  // ****************************************
  // Widths and state
  // ****************************************
  localparam int CSW      = (CH > 1) ? $clog2(CH) : 1;
  localparam int PW       = DW + CW + 1;
  localparam int CH_OFF   = (TAPS + 3) % CH;
  localparam int SEL_CTRL = 0;
  localparam int SEL_RND  = 1;
  localparam int SEL_STAT = 2;
  localparam int SEL_COEF = 16;

  typedef struct packed {
    logic [AXW-1:0]             aw_addr;
    logic                       aw_full;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    logic                       w_full;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [1:0]                 rresp;
    logic [31:0]                rdata;
    sfir_pkg::sfir_ctrl_t       ctrl;
    logic [31:0]                rnd;
    logic [TAPS-1:0][CW-1:0]    coef;
    logic [DW-1:0]              x_in;
    logic [TAPS-1:0][CH:0][DW-1:0] cas;
    logic [TAPS-1:0][DW-1:0]    mirror;
    logic [TAPS-1:0][PW-1:0]    prod;
    logic [TAPS-1:0][AW-1:0]    psum;
    logic [TAPS+2:0]            vld;
    logic [CSW-1:0]             sel;
    logic [2:0][DW-1:0]         hist;
    logic [2:0]                 pend;
    logic [1:0]                 ph;
    logic                       in_ready;
    logic                       res_valid;
    logic [AW-1:0]              res_data;
    logic [CSW-1:0]             res_chan;
  } sfir_state_t;

  sfir_state_t    s_q;
  sfir_state_t    s_d;
  int             wsel;
  int             rsel;
  int             cidx;
  logic [31:0]    old_w;
  logic [31:0]    wv;
  logic [31:0]    rd_w;
  logic [AW-1:0]  rnd_term;
  logic [AW-1:0]  ip_sum;
  logic [7:0]     lat_now;
  logic           is_sym;
  logic           is_mch;
  logic           is_ip;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic int sfir_decode(input logic [AXW-1:0] a);
    logic [AXW-1:0] w;
    w = {a[AXW-1:2], 2'b00};
    sfir_decode = -1;
    if (w == AXW'(sfir_pkg::OFF_CTRL))
      sfir_decode = SEL_CTRL;
    else if (w == AXW'(sfir_pkg::OFF_ROUND))
      sfir_decode = SEL_RND;
    else if (w == AXW'(sfir_pkg::OFF_STATUS))
      sfir_decode = SEL_STAT;
    else if (w >= AXW'(sfir_pkg::OFF_COEF) && w < AXW'(sfir_pkg::OFF_COEF) + AXW'(4 * TAPS))
      sfir_decode = SEL_COEF + int'((w - AXW'(sfir_pkg::OFF_COEF)) >> 2);
  endfunction : sfir_decode

  function automatic logic [31:0] sfir_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] strb);
    sfir_merge = o;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        sfir_merge[8*b +: 8] = n[8*b +: 8];
  endfunction : sfir_merge

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic signed [PW-1:0] pre;
    logic signed [PW-1:0] cf;
    pre      = '0;
    cf       = '0;
    s_d      = s_q;
    rd_w     = '0;
    old_w    = '0;
    wv       = '0;
    cidx     = 0;
    rsel     = -1;
    wsel     = -1;
    is_sym   = s_q.ctrl.mode == sfir_pkg::MODE_SYMMETRIC;
    is_mch   = s_q.ctrl.mode == sfir_pkg::MODE_MULTICH;
    is_ip    = s_q.ctrl.mode == sfir_pkg::MODE_INTERP;
    lat_now  = is_ip ? 8'(sfir_pkg::IP_LAT)
             : is_sym ? 8'(TAPS / 2 + sfir_pkg::SYS_LAT) : 8'(TAPS + sfir_pkg::SYS_LAT);

    // Rounding term for the first element
    unique case (s_q.ctrl.extra_adder_input_select)
      sfir_pkg::XSEL_DYNAMIC: rnd_term = AW'($signed(s_q.rnd));
      sfir_pkg::XSEL_STATIC:  rnd_term = STATIC_ROUND;
      default:                rnd_term = '0;
    endcase

    // Write channel
    if (awvalid && s_q.awready)
    begin
      s_d.aw_addr = awaddr;
      s_d.aw_full = 1'b1;
    end
    if (wvalid && s_q.wready)
    begin
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
      s_d.w_full = 1'b1;
    end
    if (s_q.bvalid && bready)
      s_d.bvalid = 1'b0;
    if (s_d.aw_full && s_d.w_full && !s_d.bvalid)
    begin
      wsel = sfir_decode(s_d.aw_addr);
      cidx = (wsel >= SEL_COEF) ? wsel - SEL_COEF : 0;
      old_w = (wsel == SEL_CTRL) ? 32'(s_q.ctrl)
            : (wsel == SEL_RND) ? s_q.rnd : 32'(s_q.coef[cidx]);
      wv = sfir_merge(old_w, s_d.w_data, s_d.w_strb);
      if (wsel == SEL_CTRL)
        s_d.ctrl = sfir_pkg::sfir_ctrl_t'(wv[sfir_pkg::CTRL_W-1:0]);
      else if (wsel == SEL_RND)
        s_d.rnd = wv;
      else if (wsel >= SEL_COEF)
        s_d.coef[cidx] = wv[CW-1:0];
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = (wsel < 0) ? sfir_pkg::RESP_SLVERR : sfir_pkg::RESP_OKAY;
    end
    s_d.awready = !s_d.aw_full && !s_d.bvalid;
    s_d.wready  = !s_d.w_full && !s_d.bvalid;

    // Read channel
    if (s_q.rvalid && rready)
      s_d.rvalid = 1'b0;
    if (arvalid && s_q.arready)
    begin
      rsel = sfir_decode(araddr);
      if (rsel == SEL_CTRL)
        rd_w = 32'(s_q.ctrl);
      else if (rsel == SEL_RND)
        rd_w = s_q.rnd;
      else if (rsel == SEL_STAT)
      begin
        rd_w[sfir_pkg::ST_LAT_LSB +: sfir_pkg::ST_LAT_W] = lat_now;
        rd_w[sfir_pkg::ST_RDY_BIT] = s_q.in_ready;
        rd_w[sfir_pkg::ST_PEND_LSB +: 3] = s_q.pend;
        rd_w[sfir_pkg::ST_SEL_LSB +: CSW] = s_q.sel;
      end
      else if (rsel >= SEL_COEF)
        rd_w = 32'(s_q.coef[rsel - SEL_COEF]);
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_w;
      s_d.rresp  = (rsel < 0) ? sfir_pkg::RESP_SLVERR : sfir_pkg::RESP_OKAY;
    end
    s_d.arready = !s_d.rvalid;

    // Channel selector and input register
    s_d.sel  = (int'(s_q.sel) == CH - 1) ? '0 : s_q.sel + 1'b1;
    s_d.x_in = is_mch ? ch_data[s_q.sel] : in_data;
    s_d.vld  = {s_q.vld[TAPS+1:0], in_valid || is_mch};

    // Mirror delay, one stage held per element
    s_d.mirror = {s_q.mirror[TAPS-2:0], s_q.x_in};

    // Systolic elements
    for (int k = 0; k < TAPS; k++)
    begin
      s_d.cas[k][0] = (k == 0) ? s_q.x_in : s_q.cas[(k + TAPS - 1) % TAPS][is_mch ? CH : 1];
      s_d.cas[k][CH:1] = s_q.cas[k][CH-1:0];
      pre = PW'($signed(s_q.cas[k][0]));
      if (is_sym)
        pre = pre + PW'($signed(s_q.mirror[TAPS-1]));
      cf = PW'($signed(s_q.coef[k]));
      s_d.prod[k] = s_q.ctrl.swap ? PW'(cf * pre) : PW'(pre * cf);
      s_d.psum[k] = ((k == 0) ? rnd_term : s_q.psum[(k + TAPS - 1) % TAPS])
                  + AW'($signed(s_q.prod[k]));
    end

    // Interpolator phases
    ip_sum = rnd_term;
    for (int j = 0; j < sfir_pkg::IP_PHASE_TAPS; j++)
      ip_sum = ip_sum + AW'($signed(s_q.coef[int'(s_q.ph) + sfir_pkg::IP_RATIO * j]))
                      * AW'($signed(s_q.hist[j]));

    // Result selection
    s_d.res_valid = 1'b0;
    s_d.res_chan  = '0;
    if (is_ip)
    begin
      if (s_q.pend != '0)
      begin
        s_d.res_data  = ip_sum;
        s_d.res_valid = 1'b1;
        s_d.ph        = s_q.ph + 1'b1;
        s_d.pend      = s_q.pend - 1'b1;
      end
      if (in_valid && s_q.in_ready)
      begin
        s_d.hist = {s_q.hist[1:0], in_data};
        s_d.pend = 3'(sfir_pkg::IP_RATIO);
        s_d.ph   = '0;
      end
    end
    else
    begin
      s_d.pend = '0;
      s_d.ph   = '0;
      if (is_sym)
      begin
        s_d.res_data  = s_q.psum[TAPS/2-1];
        s_d.res_valid = s_q.vld[TAPS/2+2];
      end
      else
      begin
        s_d.res_data  = s_q.psum[TAPS-1];
        s_d.res_valid = s_q.vld[TAPS+2];
        if (is_mch)
          s_d.res_chan = CSW'((int'(s_q.sel) + CH - CH_OFF) % CH);
      end
    end
    s_d.in_ready = !is_ip || (s_d.pend <= 3'h1);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q          <= '0;
      s_q.in_ready <= 1'b1;
      s_q.ctrl     <= sfir_pkg::sfir_ctrl_t'(sfir_pkg::CTRL_RST[sfir_pkg::CTRL_W-1:0]);
      s_q.rnd      <= sfir_pkg::ROUND_RST;
      s_q.coef     <= {TAPS{sfir_pkg::COEF_RST[CW-1:0]}};
    end
    else
      s_q <= s_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign in_ready     = s_q.in_ready;
  assign result_data  = s_q.res_data;
  assign result_valid = s_q.res_valid;
  assign result_chan  = s_q.res_chan;
  assign awready      = s_q.awready;
  assign wready       = s_q.wready;
  assign bresp        = s_q.bresp;
  assign bvalid       = s_q.bvalid;
  assign arready      = s_q.arready;
  assign rdata        = s_q.rdata;
  assign rresp        = s_q.rresp;
  assign rvalid       = s_q.rvalid;

endmodule : sfir_top
`default_nettype wire

// ===== bench/sfir_chk_assertions.sv
// Port checker for the systolic FIR filter
`timescale 1ns/1ps
`default_nettype none
module sfir_chk #(
  parameter int CH  = 4,
  parameter int CSW = (CH > 1) ? $clog2(CH) : 1
) (
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire logic           in_ready,
  input wire logic           result_valid,
  input wire logic [CSW-1:0] result_chan,
  input wire logic           awvalid,
  input wire logic           awready,
  input wire logic           wvalid,
  input wire logic           wready,
  input wire logic [1:0]     bresp,
  input wire logic           bvalid,
  input wire logic           bready,
  input wire logic           arvalid,
  input wire logic           arready,
  input wire logic [31:0]    rdata,
  input wire logic           rvalid,
  input wire logic           rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_WR_ANSWER: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response late");
  AST_WR_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_WR_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data late");
  AST_RD_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_IN_REFUSE: assert property ($fell(in_ready) |-> !in_ready [*3] ##1 in_ready)
    else $error("input refusal length wrong");
  AST_IP_FOUR: assert property ($fell(in_ready) |-> ##1 result_valid [*4])
    else $error("four outputs per input missing");
  AST_CHAN_STEP: assert property (result_valid && result_chan != '0 |=>
    result_valid && result_chan == CSW'($past(result_chan) + 1))
    else $error("channel sequence broken");
endmodule : sfir_chk
bind sfir_top sfir_chk #(.CH(CH)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .in_ready(in_ready), .result_valid(result_valid), .result_chan(result_chan),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready));
`default_nettype wire

// ===== bench/sfir_src.sv
// Upstream sample source model
`timescale 1ns/1ps
`default_nettype none
module sfir_src #(
  parameter int CH = 4,
  parameter int DW = 16
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  run,
  input  wire logic                  in_ready,
  output var  logic [DW-1:0]         in_data,
  output var  logic                  in_valid,
  output var  logic [CH-1:0][DW-1:0] ch_data
);
  int n;
  int k;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      n <= 0;
      k <= 0;
      in_valid <= 1'b0;
      in_data <= '0;
      ch_data <= '0;
    end
    else
    begin
      in_valid <= 1'b1;
      k <= (k + 1) % CH;
      if (in_valid && in_ready)
      begin
        n <= n + 1;
        in_data <= run ? DW'((n * 37) % 201 - 100) : '0;
      end
      if (k == 0)
        for (int c = 0; c < CH; c++)
          ch_data[c] <= run ? DW'((n * (c + 3)) % 97 - 48) : '0;
    end
  end
endmodule : sfir_src
`default_nettype wire

// ===== bench/sfir_top_tb_top.sv
// Testbench for the systolic FIR filter
`timescale 1ns/1ps
`default_nettype none
module sfir_top_tb_top;
  localparam int T = 12;
  localparam int CH = 4;
  logic aclk, aresetn, run, in_valid, in_ready, result_valid;
  logic [15:0] in_data;
  logic [CH-1:0][15:0] ch_data;
  logic [47:0] result_data;
  logic [1:0] result_chan, bresp, rresp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  longint cf [T];
  longint h0 [T];
  longint hm [CH][T];
  logic [47:0] ed [64];
  logic [1:0] ec [64];
  bit ev [64];
  int cyc, sc, s, md, err_total, samples_checked;
  int cv [7] = '{0, 4, 8, 16, 1, 3, 2};
  longint rnd, y;
  bit en;
  sfir_top #(.STATIC_ROUND(48'h7)) DUT (.aclk(aclk), .aresetn(aresetn),
    .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready), .ch_data(ch_data),
    .result_data(result_data), .result_valid(result_valid), .result_chan(result_chan),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  sfir_src #(.CH(CH), .DW(16)) u_src (.aclk(aclk), .aresetn(aresetn), .run(run),
    .in_ready(in_ready), .in_data(in_data), .in_valid(in_valid), .ch_data(ch_data));
  // ****
  // Checking and bus tasks
  // ****
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] ex);
    samples_checked++;
    if (seen !== ex)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  function automatic void put(int d, longint v, int c);
    ed[(cyc + d) % 64] = 48'(v);
    ec[(cyc + d) % 64] = 2'(c);
    ev[(cyc + d) % 64] = 1'b1;
  endfunction : put
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit pa;
    bit pw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw)
    begin
      @(negedge aclk);
      if (awready) pa = 0;
      if (wready) pw = 0;
      @(posedge aclk);
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b1;
    @(negedge aclk);
    chk("bresp", 64'(bresp), 64'(er));
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b1;
    @(negedge aclk);
    chk("rdata", 64'(rdata), 64'(ex));
    chk("rresp", 64'(rresp), 64'(er));
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axr
  // ****
  // Reference model and timeout
  // ****
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
    s = cyc % 64;
    if (en)
    begin
      chk("result_valid", 64'(result_valid), 64'(ev[s]));
      if (ev[s] && result_valid)
      begin
        chk("result_data", 64'(result_data), 64'(ed[s]));
        chk("result_chan", 64'(result_chan), 64'(ec[s]));
      end
    end
    ev[s] = 1'b0;
    if (!aresetn)
      sc = 0;
    else
    begin
      if (md == 2)
      begin
        for (int k = T - 1; k > 0; k--) hm[sc][k] = hm[sc][k-1];
        hm[sc][0] = longint'($signed(ch_data[sc]));
        y = rnd;
        for (int k = 0; k < T; k++) y += cf[k] * hm[sc][k];
        put(T + 4, y, sc);
      end
      else if (in_valid && in_ready)
      begin
        for (int k = T - 1; k > 0; k--) h0[k] = h0[k-1];
        h0[0] = longint'($signed(in_data));
        if (md == 3)
          for (int p = 0; p < 4; p++)
            put(2 + p, rnd + cf[p] * h0[0] + cf[p+4] * h0[1] + cf[p+8] * h0[2], 0);
        else
        begin
          y = rnd;
          for (int k = 0; k < (md == 1 ? T / 2 : T); k++)
            y += cf[k] * (h0[k] + (md == 1 ? h0[T-1-k] : 0));
          put(md == 1 ? T / 2 + 4 : T + 4, y, 0);
        end
      end
      sc = (sc + 1) % CH;
    end
  end
  initial
  begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    {aresetn, run, en, awvalid, wvalid, bready, arvalid, rready} = '0;
    {cyc, md, rnd, awaddr, araddr, wdata, err_total, samples_checked} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axr(sfir_pkg::OFF_CTRL, sfir_pkg::CTRL_RST, sfir_pkg::RESP_OKAY);
    axr(sfir_pkg::OFF_ROUND, sfir_pkg::ROUND_RST, sfir_pkg::RESP_OKAY);
    axr(sfir_pkg::OFF_COEF, sfir_pkg::COEF_RST, sfir_pkg::RESP_OKAY);
    axr(8'h0c, 32'h0000_0000, sfir_pkg::RESP_SLVERR);
    axw(8'h0c, 32'h0000_0005, sfir_pkg::RESP_SLVERR);
    axw(sfir_pkg::OFF_STATUS, 32'h0000_0001, sfir_pkg::RESP_OKAY);
    axw(sfir_pkg::OFF_ROUND, 32'h0000_0100, sfir_pkg::RESP_OKAY);
    for (int k = 0; k < T; k++)
    begin
      cf[k] = k * 3 - 7;
      axw(sfir_pkg::OFF_COEF + 8'(4 * k), 32'(cf[k]), sfir_pkg::RESP_OKAY);
    end
    axr(sfir_pkg::OFF_COEF, 32'h0000_fff9, sfir_pkg::RESP_OKAY);
    for (int i = 0; i < 7; i++)
    begin
      axw(sfir_pkg::OFF_CTRL, 32'(cv[i]), sfir_pkg::RESP_OKAY);
      md = cv[i] % 4;
      rnd = (cv[i] / 8 == 1) ? 256 : (cv[i] / 8 == 2) ? 7 : 0;
      en = 0;
      run <= 1'b0;
      repeat (80) @(posedge aclk);
      run <= 1'b1;
      en = 1;
      repeat (60) @(posedge aclk);
    end
    wrap_up();
  end
endmodule : sfir_top_tb_top
`default_nettype wire
